// [dv/smv_feed_model.sv]
// smv_feed_model.sv: position-loop side, issues the control-cycle pulse.
// assumes the same clock and synchronous reset as the supervisor.
`timescale 1ns/1ps
module smv_feed_model #(
    parameter PERIOD = 4
) (
    input wire sys_clk_i,
    input wire srst_i,
    output reg ctrl_cycle_o
);
    reg [7:0] cnt_reg;
    always @(posedge sys_clk_i) begin
        if (srst_i) begin
            cnt_reg <= 8'h00;
            ctrl_cycle_o <= 1'b0;
        end else begin
            cnt_reg <= (cnt_reg == PERIOD - 1) ? 8'h00 : cnt_reg + 8'h01;
            ctrl_cycle_o <= (cnt_reg == PERIOD - 1);
        end
    end
endmodule // smv_feed_model

// [dv/smv_sva_assertions.sv]
// smv_sva_assertions.sv: port-level checks for the motion supervisor.
// assumes one clock domain on sys_clk_i with synchronous active-high srst_i.
`timescale 1ns/1ps
module smv_sva (
    input wire sys_clk_i,
    input wire srst_i,
    input wire reg_rd_i,
    input wire [31:0] reg_rdata_o,
    input wire ctrl_cycle_i,
    input wire in_position_i,
    input wire home_return_i,
    input wire positioning_complete_o,
    input wire rough_match_out_o,
    input wire soft_limit_stop_o,
    input wire servo_lock_o,
    input wire servo_enable_input_o,
    input wire [15:0] eff_inputs_a_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (srst_i);
    // ----------------------------------------
    // assertions
    // ----------------------------------------
    chk_rdata_one_cycle:
        assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h0000_0000)
        else $error("read data seen outside its cycle");
    chk_stop_locks:
        assert property (soft_limit_stop_o |-> servo_lock_o)
        else $error("limit stop without servo lock");
    chk_home_no_stop:
        assert property ($rose(soft_limit_stop_o) |-> !$past(home_return_i))
        else $error("limit stop raised during home return");
    chk_son_follows:
        assert property (servo_enable_input_o == eff_inputs_a_o[2])
        else $error("servo enable differs from its selection bit");
    chk_complete_cause:
        assert property ($rose(positioning_complete_o) |-> $past(in_position_i))
        else $error("complete raised without in-position");
    chk_complete_drop:
        assert property (!in_position_i && !$past(in_position_i) |-> !positioning_complete_o)
        else $error("complete held without in-position");
    chk_rough_cycle:
        assert property ($changed(rough_match_out_o) |-> $past(ctrl_cycle_i))
        else $error("rough match moved off a control cycle");
    chk_stop_cycle:
        assert property ($changed(soft_limit_stop_o) |-> $past(ctrl_cycle_i))
        else $error("limit stop moved off a control cycle");
    // ----------------------------------------
    // covers
    // ----------------------------------------
    cov_stop: cover property ($rose(soft_limit_stop_o));
    cov_rough: cover property ($rose(rough_match_out_o));
    cov_complete: cover property ($rose(positioning_complete_o));
endmodule // smv_sva
bind smv_motion_supervisor smv_sva u_smv_sva (.*);

// [dv/test_servo_motion_supervision.sv]
// test_servo_motion_supervision.sv: directed bench for the supervisor.
// assumes smv_consts.vh on the include path; ms tick shortened to 10 clocks.
`timescale 1ns/1ps
`include "smv_consts.vh"
module test_servo_motion_supervision;
    localparam MS = 10;
    logic clk = 0, srst = 1, power_on = 1, wr = 0, rd = 0, ctrl, in_pos = 0, home = 0;
    logic alarm_ev = 0, irq, servo_enable_input, complete, rough, stop, lock, parerr;
    logic [7:0] addr = 8'h00, alarm_code = 8'h00;
    logic [31:0] wdata = 32'h0000_0000, rdata;
    logic signed [31:0] cmd_pos = 32'h0000_0000, remain = 32'h0000_0000;
    logic [15:0] net_in = 16'h0000, pin_in = 16'h0000, eff_a, eff_c, eff_d;
    logic [15:0] speed_tgt = 16'h0000, spd;
    int err_count = 0, checks_done = 0, cycles = 0;
    always #2 clk = ~clk;
    smv_feed_model u_feed (.sys_clk_i(clk), .srst_i(srst), .ctrl_cycle_o(ctrl));
    smv_motion_supervisor #(.MS_CYCLES(MS)) dut (
        .sys_clk_i(clk), .srst_i(srst), .power_on_i(power_on), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
        .ctrl_cycle_i(ctrl), .cmd_pos_i(cmd_pos), .remain_dist_i(remain),
        .in_position_i(in_pos), .home_return_i(home), .speed_target_i(speed_tgt),
        .alarm_event_i(alarm_ev), .alarm_code_i(alarm_code), .net_inputs_i(net_in),
        .pin_inputs_i(pin_in), .speed_cmd_o(spd), .positioning_complete_o(complete),
        .rough_match_out_o(rough), .soft_limit_stop_o(stop), .servo_lock_o(lock),
        .parameter_error_alarm_o(parerr), .servo_enable_input_o(servo_enable_input),
        .eff_inputs_a_o(eff_a), .eff_inputs_c_o(eff_c), .eff_inputs_d_o(eff_d), .irq_o(irq));
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    // one-cycle strobes with a gap, so no signal is driven twice in one step
    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rreg(input logic [7:0] a, output logic [31:0] v);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
        // data launched by the read edge still stands at this edge
        v = rdata;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string name);
        logic [31:0] v;
        rreg(a, v);
        chk(name, v, exp);
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_regs;
        rdc(`SMV_ADDR_AUTO_A, 32'h0000_0000, "auto_a reset");
        rdc(`SMV_ADDR_AUTO_C, 32'h0000_0000, "auto_c reset");
        rdc(`SMV_ADDR_AUTO_D, 32'h0000_0000, "auto_d reset");
        wreg(`SMV_ADDR_AUTO_C, 32'h0000_A5C3);
        rdc(`SMV_ADDR_AUTO_C, 32'h0000_A5C3, "auto_c rw");
        wreg(`SMV_ADDR_SCURVE, 32'h0000_03E9);
        rdc(`SMV_ADDR_SCURVE, 32'h0000_03E8, "scurve clamp");
        wreg(8'hFC, 32'h1234_5678);
        rdc(8'hFC, 32'h0000_0000, "unmapped");
        $display("t_regs done");
    endtask
    task automatic t_auto;
        wreg(`SMV_ADDR_AUTO_A, 32'h0000_0004);
        cyc(4);
        chk("son forced", servo_enable_input, 1'b1);
        chk("eff_a forced", eff_a, 16'h0004);
        wreg(`SMV_ADDR_AUTO_A, 32'h0000_0000);
        cyc(4);
        chk("son released", servo_enable_input, 1'b0);
        chk("eff_c forced", eff_c, 16'hA5C3);
        net_in <= 16'h0004;
        cyc(4);
        chk("son from net", servo_enable_input, 1'b1);
        net_in <= 16'h0000;
        pin_in <= 16'h0008;
        cyc(6);
        chk("eff_a pin", eff_a & 16'h000C, 16'h0008);
        wreg(`SMV_ADDR_AUTO_D, 32'h0000_0001);
        cyc(4);
        chk("eff_d forced", eff_d & 16'h0001, 16'h0001);
        $display("t_auto done");
    endtask
    task automatic t_rough;
        wreg(`SMV_ADDR_ROUGH, 32'h0000_0064);
        remain <= 32'h0000_0065;
        cyc(10);
        chk("rough outside", rough, 1'b0);
        remain <= 32'h0000_0064;
        cyc(10);
        chk("rough at range", rough, 1'b1);
        $display("t_rough done");
    endtask
    task automatic t_limits;
        logic i0, i1;
        logic [31:0] v;
        wreg(`SMV_ADDR_LIM_POS, 32'h0000_03E8);
        wreg(`SMV_ADDR_LIM_NEG, 32'hFFFF_FC18);
        cmd_pos <= 32'h0000_01F4;
        cyc(10);
        chk("stop inside", stop, 1'b0);
        cmd_pos <= 32'h0000_03E9;
        cyc(10);
        chk("stop beyond", stop, 1'b1);
        chk("lock beyond", lock, 1'b1);
        home <= 1'b1;
        cyc(10);
        chk("stop in home", stop, 1'b0);
        home <= 1'b0;
        wreg(`SMV_ADDR_LIM_NEG, 32'h0000_03E8);
        cyc(10);
        chk("stop equal", stop, 1'b0);
        chk("parerr equal", parerr, 1'b0);
        wreg(`SMV_ADDR_LIM_NEG, 32'h0000_03E9);
        cyc(2);
        chk("parerr below", parerr, 1'b1);
        wreg(`SMV_ADDR_IRQ_MASK, 32'h0000_0000);
        cyc(1);
        i0 = irq;
        wreg(`SMV_ADDR_IRQ_MASK, 32'h0000_000F);
        cyc(1);
        i1 = irq;
        chk("irq masked", i0, 1'b0);
        chk("irq unmasked", i1, 1'b1);
        rreg(`SMV_ADDR_IRQ_STAT, v);
        chk("irq parerr", v[3], 1'b1);
        rreg(`SMV_ADDR_IRQ_STAT, v);
        chk("irq cleared", v, 32'h0000_0000);
        chk("irq low", irq, 1'b0);
        $display("t_limits done");
    endtask
    task automatic t_scurve;
        wreg(`SMV_ADDR_SCURVE, 32'h0000_0000);
        speed_tgt <= 16'h1000;
        cyc(2);
        chk("linear pass", spd, 16'h1000);
        wreg(`SMV_ADDR_SCURVE, 32'h0000_0003);
        speed_tgt <= 16'h2000;
        cyc(2);
        chk("accel no jump", spd == 16'h2000, 1'b0);
        cyc(4 * MS);
        chk("accel reached", spd, 16'h2000);
        speed_tgt <= 16'h0000;
        cyc(MS + 2);
        chk("decel rounded", (spd < 16'h2000) && (spd != 16'h0000), 1'b1);
        cyc(4 * MS);
        chk("decel reached", spd, 16'h0000);
        $display("t_scurve done");
    endtask
    task automatic t_complete;
        int n0, n3;
        wreg(`SMV_ADDR_SCURVE, 32'h0000_0000);
        in_pos <= 1'b1;
        for (n0 = 0; n0 < 100 && complete !== 1'b1; n0++) @(posedge clk);
        in_pos <= 1'b0;
        cyc(4);
        chk("complete off", complete, 1'b0);
        wreg(`SMV_ADDR_SCURVE, 32'h0000_0003);
        in_pos <= 1'b1;
        for (n3 = 0; n3 < 100 && complete !== 1'b1; n3++) @(posedge clk);
        // one ms tick of slack for tick phase
        chk("complete delay", (n3 - n0 >= 2 * MS) && (n3 - n0 <= 4 * MS), 1'b1);
        in_pos <= 1'b0;
        $display("t_complete done");
    endtask
    task automatic t_history;
        for (int i = 1; i <= 7; i++) begin
            alarm_code <= i[7:0];
            alarm_ev <= 1'b1;
            @(posedge clk);
            alarm_ev <= 1'b0;
            @(posedge clk);
        end
        rdc(`SMV_ADDR_ALM0, 32'h0000_0007, "slot0");
        rdc(8'h40, 32'h0000_0003, "slot4");
        rdc(8'h44, 32'h0000_0002, "slot5");
        wreg(`SMV_ADDR_HCLR, 32'h0000_0001);
        cyc(4);
        rdc(`SMV_ADDR_ALM0, 32'h0000_0007, "no early clear");
        power_on <= 1'b0;
        cyc(6);
        power_on <= 1'b1;
        cyc(8);
        rdc(`SMV_ADDR_ALM0, 32'h0000_0000, "slot0 cleared");
        rdc(8'h44, 32'h0000_0000, "slot5 cleared");
        rdc(`SMV_ADDR_HCLR, 32'h0000_0000, "clear returns");
        $display("t_history done");
    endtask
    // ----------------------------------------
    // run control
    // ----------------------------------------
    task automatic conclude;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // a full run needs about 320 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            conclude();
        end
    end
    initial begin
        cyc(5);
        srst <= 1'b0;
        @(posedge clk);
        t_regs();
        t_auto();
        t_rough();
        t_limits();
        t_scurve();
        t_complete();
        t_history();
        conclude();
    end
endmodule // test_servo_motion_supervision

// [logic/smv_consts.vh]
// smv_consts.vh: register offsets, reset values and timing counts for the
// motion supervision block. assumes a 250 MHz system clock.
`ifndef SMV_CONSTS_VH
`define SMV_CONSTS_VH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define SMV_ADDR_CTRL 8'h00
`define SMV_ADDR_SCURVE 8'h04
`define SMV_ADDR_ROUGH 8'h08
`define SMV_ADDR_LIM_POS 8'h0C
`define SMV_ADDR_LIM_NEG 8'h10
`define SMV_ADDR_AUTO_A 8'h14
`define SMV_ADDR_AUTO_C 8'h18
`define SMV_ADDR_AUTO_D 8'h1C
`define SMV_ADDR_HCLR 8'h20
`define SMV_ADDR_STATUS 8'h24
`define SMV_ADDR_IRQ_STAT 8'h28
`define SMV_ADDR_IRQ_MASK 8'h2C
`define SMV_ADDR_ALM0 8'h30
// ----------------------------------------
// fields and limits
// ----------------------------------------
`define SMV_AUTO_RESET 16'h0000
`define SMV_SON_BIT 2
`define SMV_SCURVE_MAX_MS 16'h03E8
// 250 MHz: cycles per millisecond
`define SMV_CLK_KHZ 250000
`define SMV_MS_CYCLES 250000
`define SMV_ALARM_A37 8'h37
`endif

// [logic/smv_motion_supervisor.v]
// smv_motion_supervisor.v: s-curve smoothing, alarm history, rough match,
// software limits and input auto-on forcing. assumes positions arrive on
// sys_clk_i from logic in the same domain; external pins are synchronised.
// Functional notes
// - s-curve time zero gives a linear ramp both ways
// - s-curve time accepted 0 to 1000 ms, ramp ends rounded
// - positioning complete delayed by the s-curve time
// - history holds current alarm plus five past, oldest shifted out
// - history clear erases, then parameter returns to 0
// - history clear setting acts only after next power cycle
// - rough match when remaining distance within range 0..65535
// - beyond soft limit: stop and servo-lock like stroke end
// - soft limit active from power-on, off during home return
// - soft limit off when positive equals negative setting
// - positive below negative raises parameter error A37
// - auto-on bit 1 forces input, 0 takes network or pin
// - servo-on is weight 4 of lowest digit of selection a
//
// Implementation choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`include "smv_consts.vh"
module smv_motion_supervisor #(
    parameter MS_CYCLES = `SMV_MS_CYCLES,
    parameter POS_W = 32
) (
    input wire sys_clk_i,
    input wire srst_i,
    input wire power_on_i,
    input wire [7:0] reg_addr_i,
    input wire [31:0] reg_wdata_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    output reg [31:0] reg_rdata_o,
    input wire ctrl_cycle_i,
    input wire signed [POS_W-1:0] cmd_pos_i,
    input wire signed [POS_W-1:0] remain_dist_i,
    input wire in_position_i,
    input wire home_return_i,
    input wire [15:0] speed_target_i,
    input wire alarm_event_i,
    input wire [7:0] alarm_code_i,
    input wire [15:0] net_inputs_i,
    input wire [15:0] pin_inputs_i,
    output reg [15:0] speed_cmd_o,
    output reg positioning_complete_o,
    output reg rough_match_out_o,
    output reg soft_limit_stop_o,
    output reg servo_lock_o,
    output reg parameter_error_alarm_o,
    output reg servo_enable_input_o,
    output reg [15:0] eff_inputs_a_o,
    output reg [15:0] eff_inputs_c_o,
    output reg [15:0] eff_inputs_d_o,
    output reg irq_o
);
    // ----------------------------------------
    // registers
    // ----------------------------------------
    reg [15:0] s_curve_time_param_reg;
    reg [15:0] rough_match_range_param_reg;
    reg signed [POS_W-1:0] lim_pos_reg;
    reg signed [POS_W-1:0] lim_neg_reg;
    reg [15:0] input_auto_on_select_a_reg;
    reg [15:0] input_auto_on_select_c_reg;
    reg [15:0] input_auto_on_select_d_reg;
    reg alarm_history_clear_param_reg;
    reg hclr_pending_reg;
    reg [3:0] irq_stat_reg;
    reg [3:0] irq_mask_reg;
    reg [7:0] hist_reg [0:5];
    reg [15:0] pin_s1_reg;
    reg [15:0] pin_s2_reg;
    reg pwr_s1_reg;
    reg pwr_s2_reg;
    reg pwr_d_reg;
    reg [15:0] settle_cnt_reg;
    reg [15:0] ramp_ms_reg;
    reg [15:0] ramp_base_reg;
    reg rough_d_reg;
    reg stop_d_reg;
    wire ms_tick;
    wire power_rise;
    wire lim_en;
    wire over_lim;
    wire par_err;
    wire rough_hit;
    wire [3:0] ev;
    wire [15:0] abs_rem_lo;
    wire signed [POS_W-1:0] abs_rem;
    wire [2:0] hist_idx;
    integer k;

    smv_ms_tick #(.TICK_CYCLES(MS_CYCLES)) u_tick (
        .sys_clk_i(sys_clk_i),
        .srst_i(srst_i),
        .tick_o(ms_tick)
    );

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    always @(posedge sys_clk_i) begin
        if (srst_i) begin
            pin_s1_reg <= 16'h0000;
            pin_s2_reg <= 16'h0000;
            pwr_s1_reg <= 1'b0;
            pwr_s2_reg <= 1'b0;
            pwr_d_reg <= 1'b0;
        end else begin
            pin_s1_reg <= pin_inputs_i;
            pin_s2_reg <= pin_s1_reg;
            pwr_s1_reg <= power_on_i;
            pwr_s2_reg <= pwr_s1_reg;
            pwr_d_reg <= pwr_s2_reg;
        end
    end
    // power-on edge taken after the synchroniser, never from the raw pin
    assign power_rise = pwr_s2_reg & ~pwr_d_reg;

    // ----------------------------------------
    // comparisons
    // ----------------------------------------
    // equal limits disable
    assign lim_en = (lim_pos_reg != lim_neg_reg) && !home_return_i;
    assign par_err = lim_pos_reg < lim_neg_reg;
    assign over_lim = lim_en && !par_err &&
        ((cmd_pos_i > lim_pos_reg) || (cmd_pos_i < lim_neg_reg));
    // magnitude, so the rough window works in both travel directions
    assign abs_rem = remain_dist_i[POS_W-1] ? -remain_dist_i : remain_dist_i;
    assign abs_rem_lo = abs_rem[15:0];
    // slot n sits at 0x30 + 4n; the 3-bit sum wraps 0x30 back to slot 0
    assign hist_idx = reg_addr_i[4:2] + 3'h4;
    assign rough_hit = (abs_rem[POS_W-1:16] == 0) &&
        (abs_rem_lo <= rough_match_range_param_reg);
    // condition events are rising edges, so a held condition is counted once; alarm_event_i is taken as it stands
    assign ev = {par_err & ~parameter_error_alarm_o, over_lim & ~stop_d_reg,
        rough_hit & ~rough_d_reg, alarm_event_i};

    // ----------------------------------------
    // register writes and events
    // ----------------------------------------
    always @(posedge sys_clk_i) begin
        if (srst_i) begin
            s_curve_time_param_reg <= 16'h0000;
            rough_match_range_param_reg <= 16'h0000;
            lim_pos_reg <= {POS_W{1'b0}};
            lim_neg_reg <= {POS_W{1'b0}};
            input_auto_on_select_a_reg <= `SMV_AUTO_RESET;
            input_auto_on_select_c_reg <= `SMV_AUTO_RESET;
            input_auto_on_select_d_reg <= `SMV_AUTO_RESET;
            alarm_history_clear_param_reg <= 1'b0;
            hclr_pending_reg <= 1'b0;
            irq_stat_reg <= 4'h0;
            irq_mask_reg <= 4'h0;
            for (k = 0; k < 6; k = k + 1) begin
                hist_reg[k] <= 8'h00;
            end
        end else begin
            if (reg_wr_i) begin
                if (reg_addr_i == `SMV_ADDR_SCURVE) begin
                    if (reg_wdata_i[15:0] > `SMV_SCURVE_MAX_MS) begin
                        s_curve_time_param_reg <= `SMV_SCURVE_MAX_MS;
                    end else begin
                        s_curve_time_param_reg <= reg_wdata_i[15:0];
                    end
                end else if (reg_addr_i == `SMV_ADDR_ROUGH) begin
                    rough_match_range_param_reg <= reg_wdata_i[15:0];
                end else if (reg_addr_i == `SMV_ADDR_LIM_POS) begin
                    lim_pos_reg <= reg_wdata_i[POS_W-1:0];
                end else if (reg_addr_i == `SMV_ADDR_LIM_NEG) begin
                    lim_neg_reg <= reg_wdata_i[POS_W-1:0];
                end else if (reg_addr_i == `SMV_ADDR_AUTO_A) begin
                    input_auto_on_select_a_reg <= reg_wdata_i[15:0];
                end else if (reg_addr_i == `SMV_ADDR_AUTO_C) begin
                    input_auto_on_select_c_reg <= reg_wdata_i[15:0];
                end else if (reg_addr_i == `SMV_ADDR_AUTO_D) begin
                    input_auto_on_select_d_reg <= reg_wdata_i[15:0];
                end else if (reg_addr_i == `SMV_ADDR_HCLR) begin
                    alarm_history_clear_param_reg <= reg_wdata_i[0];
                end else if (reg_addr_i == `SMV_ADDR_IRQ_MASK) begin
                    irq_mask_reg <= reg_wdata_i[3:0];
                end
            end
            // events win over the read clear
            if (reg_rd_i && reg_addr_i == `SMV_ADDR_IRQ_STAT) begin
                irq_stat_reg <= ev;
            end else begin
                irq_stat_reg <= irq_stat_reg | ev;
            end
            if (!pwr_s2_reg && alarm_history_clear_param_reg) begin
                hclr_pending_reg <= 1'b1;
            end
            if (power_rise && hclr_pending_reg) begin
                for (k = 0; k < 6; k = k + 1) begin
                    hist_reg[k] <= 8'h00;
                end
                alarm_history_clear_param_reg <= 1'b0;
                hclr_pending_reg <= 1'b0;
            end else if (alarm_event_i) begin
                hist_reg[0] <= alarm_code_i;
                for (k = 1; k < 6; k = k + 1) begin
                    hist_reg[k] <= hist_reg[k-1];
                end
            end
        end
    end

    // ----------------------------------------
    // s-curve, completion and outputs
    // ----------------------------------------
    always @(posedge sys_clk_i) begin
        if (srst_i) begin
            speed_cmd_o <= 16'h0000;
            ramp_ms_reg <= 16'h0000;
            ramp_base_reg <= 16'h0000;
            settle_cnt_reg <= 16'h0000;
            positioning_complete_o <= 1'b0;
            rough_match_out_o <= 1'b0;
            soft_limit_stop_o <= 1'b0;
            servo_lock_o <= 1'b0;
            parameter_error_alarm_o <= 1'b0;
            rough_d_reg <= 1'b0;
            stop_d_reg <= 1'b0;
            irq_o <= 1'b0;
        end else begin
            if (s_curve_time_param_reg == 16'h0000) begin
                speed_cmd_o <= speed_target_i;
                ramp_ms_reg <= 16'h0000;
                ramp_base_reg <= speed_target_i;
            end else if (ms_tick) begin
                if (ramp_ms_reg >= s_curve_time_param_reg - 16'h0001) begin
                    speed_cmd_o <= speed_target_i;
                    ramp_base_reg <= speed_target_i;
                    ramp_ms_reg <= 16'h0000;
                end else if (speed_target_i != ramp_base_reg) begin
                    ramp_ms_reg <= ramp_ms_reg + 16'h0001;
                    // unsigned difference must not wrap when slowing down
                    if (speed_target_i > speed_cmd_o) begin
                        speed_cmd_o <= speed_cmd_o +
                            ((speed_target_i - speed_cmd_o) >> 2);
                    end else begin
                        speed_cmd_o <= speed_cmd_o -
                            ((speed_cmd_o - speed_target_i) >> 2);
                    end
                end
            end
            // ticks run free, so the wait after in-position is Ts-1 to Ts ms;
            // sharing the one divider saves a counter per timer
            // extra Ts before complete
            if (!in_position_i) begin
                settle_cnt_reg <= 16'h0000;
                positioning_complete_o <= 1'b0;
            end else if (settle_cnt_reg >= s_curve_time_param_reg) begin
                positioning_complete_o <= 1'b1;
            end else if (ms_tick) begin
                settle_cnt_reg <= settle_cnt_reg + 16'h0001;
            end
            if (ctrl_cycle_i) begin
                rough_match_out_o <= rough_hit;
                rough_d_reg <= rough_hit;
                soft_limit_stop_o <= over_lim;
                servo_lock_o <= over_lim;
                stop_d_reg <= over_lim;
            end
            parameter_error_alarm_o <= par_err;
            irq_o <= |(irq_stat_reg & irq_mask_reg);
        end
    end

    // ----------------------------------------
    // auto-on input forcing
    // ----------------------------------------
    always @(posedge sys_clk_i) begin
        if (srst_i) begin
            eff_inputs_a_o <= 16'h0000;
            eff_inputs_c_o <= 16'h0000;
            eff_inputs_d_o <= 16'h0000;
            servo_enable_input_o <= 1'b0;
        end else begin
            eff_inputs_a_o <= input_auto_on_select_a_reg | net_inputs_i | pin_s2_reg;
            eff_inputs_c_o <= input_auto_on_select_c_reg | net_inputs_i | pin_s2_reg;
            eff_inputs_d_o <= input_auto_on_select_d_reg | net_inputs_i | pin_s2_reg;
            servo_enable_input_o <= input_auto_on_select_a_reg[`SMV_SON_BIT] |
                net_inputs_i[`SMV_SON_BIT] | pin_s2_reg[`SMV_SON_BIT];
        end
    end

    // ----------------------------------------
    // read port
    // ----------------------------------------
    always @(posedge sys_clk_i) begin
        if (srst_i) begin
            reg_rdata_o <= 32'h0000_0000;
        end else if (reg_rd_i) begin
            if (reg_addr_i == `SMV_ADDR_SCURVE) begin
                reg_rdata_o <= {16'h0000, s_curve_time_param_reg};
            end else if (reg_addr_i == `SMV_ADDR_ROUGH) begin
                reg_rdata_o <= {16'h0000, rough_match_range_param_reg};
            end else if (reg_addr_i == `SMV_ADDR_LIM_POS) begin
                reg_rdata_o <= lim_pos_reg;
            end else if (reg_addr_i == `SMV_ADDR_LIM_NEG) begin
                reg_rdata_o <= lim_neg_reg;
            end else if (reg_addr_i == `SMV_ADDR_AUTO_A) begin
                reg_rdata_o <= {16'h0000, input_auto_on_select_a_reg};
            end else if (reg_addr_i == `SMV_ADDR_AUTO_C) begin
                reg_rdata_o <= {16'h0000, input_auto_on_select_c_reg};
            end else if (reg_addr_i == `SMV_ADDR_AUTO_D) begin
                reg_rdata_o <= {16'h0000, input_auto_on_select_d_reg};
            end else if (reg_addr_i == `SMV_ADDR_HCLR) begin
                reg_rdata_o <= {31'h0000_0000, alarm_history_clear_param_reg};
            end else if (reg_addr_i == `SMV_ADDR_STATUS) begin
                reg_rdata_o <= {26'h000_0000, lim_en, parameter_error_alarm_o,
                    servo_lock_o, soft_limit_stop_o, rough_match_out_o,
                    positioning_complete_o};
            end else if (reg_addr_i == `SMV_ADDR_IRQ_STAT) begin
                reg_rdata_o <= {28'h000_0000, irq_stat_reg};
            end else if (reg_addr_i == `SMV_ADDR_IRQ_MASK) begin
                reg_rdata_o <= {28'h000_0000, irq_mask_reg};
            end else if (reg_addr_i >= `SMV_ADDR_ALM0 && reg_addr_i <= 8'h44) begin
                reg_rdata_o <= {24'h00_0000, hist_reg[hist_idx]};
            end else begin
                reg_rdata_o <= 32'h0000_0000;
            end
        end else begin
            reg_rdata_o <= 32'h0000_0000;
        end
    end
endmodule // smv_motion_supervisor

// [logic/smv_ms_tick.v]
// smv_ms_tick.v: one-cycle enable pulse every TICK_CYCLES clocks.
// assumes a single free-running clock and synchronous reset.
`timescale 1ns/1ps
module smv_ms_tick #(
    parameter TICK_CYCLES = 250000
) (
    input wire sys_clk_i,
    input wire srst_i,
    output reg tick_o
);
    reg [31:0] cnt_reg;
    always @(posedge sys_clk_i) begin
        if (srst_i) begin
            cnt_reg <= 32'h0000_0000;
            tick_o <= 1'b0;
        end else if (cnt_reg >= TICK_CYCLES - 1) begin
            cnt_reg <= 32'h0000_0000;
            tick_o <= 1'b1;
        end else begin
            cnt_reg <= cnt_reg + 32'h0000_0001;
            tick_o <= 1'b0;
        end
    end
endmodule // smv_ms_tick
